// ---- apc_pkg.sv ----
package apc_pkg;
	localparam int PCLK_MHZ = 20;
	localparam int PCLK_KHZ = PCLK_MHZ * 1000;
	localparam int DLY_W = 20;

	// Reset interval after power-up
	localparam int BOOT_US = 10;
	localparam int BOOT_CYC = BOOT_US * PCLK_MHZ;

	// Internal conversion clock
	localparam int INT_FAST_KHZ = 1800;
	localparam int INT_SLOW_KHZ = 225;
	localparam logic [6:0] INT_FAST_DIV = 7'(PCLK_KHZ / INT_FAST_KHZ);
	localparam logic [6:0] INT_SLOW_DIV = 7'(PCLK_KHZ / INT_SLOW_KHZ);
	localparam logic [3:0] CONV_STEPS = 4'hC;
	localparam logic [3:0] EXT_STEPS = 4'hC;
	localparam logic [2:0] CTRL_LAST = 3'h6;

	// Power-mode bits of the control byte
	localparam logic [1:0] PD_FULL = 2'h0;
	localparam logic [1:0] PD_FAST = 2'h1;
	localparam logic [1:0] PD_INT = 2'h2;
	localparam logic [1:0] PD_EXT = 2'h3;
	localparam logic [1:0] PD_RESET = PD_INT;

	// Serial clock made by the host
	localparam int SCLK_KHZ = 400;
	localparam int SCLK_HALF = (PCLK_KHZ + 2 * SCLK_KHZ - 1) / (2 * SCLK_KHZ);
	localparam logic [4:0] CTRL_BITS = 5'h08;
	localparam logic [4:0] READ_BITS = 5'h10;

	// Power-up delays
	localparam int FAST_UP_US = 5;
	localparam int FAST_UP_CYC = FAST_UP_US * PCLK_MHZ;
	localparam int FULL_UP_US = 300;
	localparam int FULL_UP_CYC = FULL_UP_US * PCLK_MHZ;
	localparam int EXTC_UP_MS = 20;
	localparam int EXTC_UP_CYC = EXTC_UP_MS * PCLK_KHZ;
	localparam int EXT_SETTLE_US = 75;
	localparam int EXT_SETTLE_CYC = EXT_SETTLE_US * PCLK_MHZ;

	// Sampling-rate limits as least frame spacing
	localparam int RATE_INT_KSPS = 26;
	localparam int RATE_EXT_KSPS = 133;
	localparam int GAP_INT_CYC = (PCLK_KHZ + RATE_INT_KSPS - 1) / RATE_INT_KSPS;
	localparam int GAP_EXT_CYC = (PCLK_KHZ + RATE_EXT_KSPS - 1) / RATE_EXT_KSPS;

	// Host register map
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] SHUTDOWN_SELECT_PIN_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] RXDATA_OFS = 8'h0C;
	localparam int CMD_WAIT_BIT = 8;
	localparam int CMD_READ_BIT = 9;
	localparam logic [9:0] CMD_RESET = 10'h000;

	// Shutdown pin setting
	localparam logic [1:0] SHUTDOWN_SELECT_PIN_LOW = 2'h0;
	localparam logic [1:0] SHUTDOWN_SELECT_PIN_FLOAT = 2'h1;
	localparam logic [1:0] SHUTDOWN_SELECT_PIN_HIGH = 2'h2;
	localparam logic [1:0] SHUTDOWN_SELECT_PIN_RESET = SHUTDOWN_SELECT_PIN_HIGH;

	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_INT_CONV,
		DEV_EXT_CONV
	} apc_dev_state_type;

	typedef enum logic [2:0] {
		H_BOOT,
		H_IDLE,
		H_PWRUP,
		H_SHIFT,
		H_WSTRB,
		H_READ,
		H_GAP
	} apc_host_state_type;
endpackage

// ---- apc_link_if.sv ----
`timescale 1ns/1ps
interface apc_link_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic dout;
	logic dout_oe_n;
	logic serial_strobe_out;
	logic serial_strobe_out_oe_n;
	logic shutdown_select_pin_o;
	logic shutdown_select_pin_oe_n;
	logic dout_line;
	logic serial_strobe_out_line;
	logic shutdown_select_pin_high;
	logic shutdown_select_pin_float;
	logic shutdown_select_pin_low;

	// Undriven lines read as low
	assign dout_line = ~dout_oe_n & dout;
	assign serial_strobe_out_line = ~serial_strobe_out_oe_n & serial_strobe_out;
	// Three-level decode of the shutdown select pin
	assign shutdown_select_pin_high = ~shutdown_select_pin_oe_n & shutdown_select_pin_o;
	assign shutdown_select_pin_low = ~shutdown_select_pin_oe_n & ~shutdown_select_pin_o;
	assign shutdown_select_pin_float = shutdown_select_pin_oe_n;

	modport dev (
		input sclk,
		input cs_n,
		input din,
		input shutdown_select_pin_high,
		input shutdown_select_pin_float,
		input shutdown_select_pin_low,
		output dout,
		output dout_oe_n,
		output serial_strobe_out,
		output serial_strobe_out_oe_n
	);

	modport host (
		output sclk,
		output cs_n,
		output din,
		output shutdown_select_pin_o,
		output shutdown_select_pin_oe_n,
		input dout_line,
		input serial_strobe_out_line
	);
endinterface

// ---- apc_device.sv ----
// Functional notes
// - Reset to internal clock, strobe high
// - Host waits 10 us after power-up
// - Zeros out until first conversion; start bit
// - Floating pin external, high internal compensation
// - Internal clock 1.8 MHz floating, 225 kHz high
// - Serial clock limits with internal compensation
// - Power bits: full, fast, internal, external
// - Sleeping keeps interface, no conversion
// - Pin low shuts down, overrides bits
// - Finish conversion in old mode, then sleep
// - Result still readable while asleep internally
// - First one bit wakes and starts
// - Upper bit stays up; zeros sleep again
// - Pin low aborts conversion at once
// - Host allows power-up delay before converting
// - Host waits 20 ms, discharged external cap
// - Host keeps sampling rate within limits
// - External compensation: 75 us, dummy conversion
// - Serial clock never below 100 kHz
// - Spend reference settling in fast sleep
// - Operational within 2 us of pin high
// - Strobe low during internal conversion
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module apc_device (
	input wire logic pclk,
	input wire logic presetn,
	apc_link_if.dev link,
	input wire logic [11:0] sample_value,
	output logic [1:0] power_mode,
	output logic ext_clock_mode,
	output logic comp_internal,
	output logic conv_busy,
	output logic asleep,
	output logic hw_down,
	output logic [11:0] result
);
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic sclk_d_r;
	logic rx_active_r;
	logic rx_full_r;
	logic [2:0] rx_cnt_r;
	logic [6:0] rx_sr_r;
	logic [1:0] pd_r;
	logic ext_mode_r;
	logic asleep_r;
	apc_pkg::apc_dev_state_type state_r;
	logic [3:0] conv_cnt_r;
	logic [6:0] div_cnt_r;
	logic [11:0] result_r;
	logic [15:0] out_sr_r;
	logic dout_r;
	logic dout_oe_n_r;
	logic serial_strobe_out_r;
	logic serial_strobe_out_oe_n_r;
	logic comp_internal_r;
	logic hw_down_r;
	logic conv_busy_r;
	logic sclk_s;
	logic cs_low;
	logic din_s;
	logic shutdown_select_pin_high_s;
	logic shutdown_select_pin_float_s;
	logic shutdown_select_pin_low_s;
	logic rise;
	logic fall;
	logic start_bit;
	logic byte_go;
	logic [1:0] new_pd;
	logic conv_ext;
	logic [6:0] int_period;
	logic tick;
	logic int_done;
	logic ext_done;
	logic conv_done;

	// Two-stage synchroniser for all link inputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_r <= 6'h10;
			sync2_r <= 6'h10;
		end
		else
		begin
			sync1_r <= {link.sclk, link.cs_n, link.din, link.shutdown_select_pin_high,
				link.shutdown_select_pin_float, link.shutdown_select_pin_low};
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sclk_d_r <= 1'b0;
		else
			sclk_d_r <= sync2_r[5];
	end

	assign sclk_s = sync2_r[5];
	assign cs_low = ~sync2_r[4];
	assign din_s = sync2_r[3];
	assign shutdown_select_pin_high_s = sync2_r[2];
	assign shutdown_select_pin_float_s = sync2_r[1];
	assign shutdown_select_pin_low_s = sync2_r[0];
	assign rise = sclk_s & ~sclk_d_r;
	assign fall = ~sclk_s & sclk_d_r;

	// First one bit with chip select low, any time not in an internal conversion or with the pin low
	assign start_bit = rise & cs_low & din_s & ~shutdown_select_pin_low_s & ~rx_active_r
		& ~rx_full_r & (state_r != apc_pkg::DEV_INT_CONV);
	// Conversion begins on the falling edge after the last control bit
	assign byte_go = fall & rx_full_r & cs_low & ~shutdown_select_pin_low_s;
	assign new_pd = rx_sr_r[1:0];
	// Power-down bytes convert in the previous clock mode
	assign conv_ext = new_pd[1] ? new_pd[0] : ext_mode_r;
	assign int_period = shutdown_select_pin_float_s ? apc_pkg::INT_FAST_DIV
		: apc_pkg::INT_SLOW_DIV;
	assign tick = (div_cnt_r == int_period - 7'h01);
	assign int_done = (state_r == apc_pkg::DEV_INT_CONV) & tick
		& (conv_cnt_r == apc_pkg::CONV_STEPS - 4'h1);
	assign ext_done = (state_r == apc_pkg::DEV_EXT_CONV) & fall & cs_low
		& (conv_cnt_r == apc_pkg::EXT_STEPS - 4'h1);
	assign conv_done = ~shutdown_select_pin_low_s & ~byte_go & (int_done | ext_done);

	// Control byte receiver
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_active_r <= 1'b0;
			rx_full_r <= 1'b0;
			rx_cnt_r <= 3'h0;
			rx_sr_r <= 7'h00;
		end
		else if (shutdown_select_pin_low_s || !cs_low)
		begin
			rx_active_r <= 1'b0;
			rx_full_r <= 1'b0;
		end
		else if (start_bit)
		begin
			rx_active_r <= 1'b1;
			rx_cnt_r <= 3'h0;
		end
		else if (rise && rx_active_r)
		begin
			rx_sr_r <= {rx_sr_r[5:0], din_s};
			rx_cnt_r <= rx_cnt_r + 3'h1;
			if (rx_cnt_r == apc_pkg::CTRL_LAST)
			begin
				rx_active_r <= 1'b0;
				rx_full_r <= 1'b1;
			end
		end
		else if (fall && rx_full_r)
			rx_full_r <= 1'b0;
	end

	// Power mode and clock mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pd_r <= apc_pkg::PD_RESET;
			ext_mode_r <= 1'b0;
		end
		else if (byte_go)
		begin
			pd_r <= new_pd;
			if (new_pd[1])
				ext_mode_r <= new_pd[0];
		end
	end

	// Software sleep; the interface keeps running meanwhile
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			asleep_r <= 1'b0;
		else if (start_bit)
			asleep_r <= 1'b0;
		else if (conv_done && !pd_r[1])
			asleep_r <= 1'b1;
	end

	// Conversion sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= apc_pkg::DEV_IDLE;
			conv_cnt_r <= 4'h0;
			div_cnt_r <= 7'h00;
		end
		else if (shutdown_select_pin_low_s)
			state_r <= apc_pkg::DEV_IDLE;
		else if (byte_go)
		begin
			state_r <= conv_ext ? apc_pkg::DEV_EXT_CONV
				: apc_pkg::DEV_INT_CONV;
			conv_cnt_r <= 4'h0;
			div_cnt_r <= 7'h00;
		end
		else
		begin
			case (state_r)
				apc_pkg::DEV_INT_CONV:
				begin
					div_cnt_r <= tick ? 7'h00 : div_cnt_r + 7'h01;
					if (tick)
						conv_cnt_r <= conv_cnt_r + 4'h1;
					if (int_done)
						state_r <= apc_pkg::DEV_IDLE;
				end
				apc_pkg::DEV_EXT_CONV:
				begin
					if (!cs_low)
						state_r <= apc_pkg::DEV_IDLE;
					else if (fall)
					begin
						conv_cnt_r <= conv_cnt_r + 4'h1;
						if (ext_done)
							state_r <= apc_pkg::DEV_IDLE;
					end
				end
				default:
					state_r <= apc_pkg::DEV_IDLE;
			endcase
		end
	end

	// Result register and output shifter; shifts even when asleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result_r <= 12'h000;
			out_sr_r <= 16'h0000;
			dout_r <= 1'b0;
		end
		else if (conv_done && state_r == apc_pkg::DEV_INT_CONV)
		begin
			result_r <= sample_value;
			out_sr_r <= {sample_value, 4'h0};
			dout_r <= 1'b0;
		end
		else if (byte_go && conv_ext)
		begin
			result_r <= sample_value;
			out_sr_r <= {1'b0, sample_value, 3'h0};
			dout_r <= 1'b0;
		end
		else if (fall && cs_low)
		begin
			dout_r <= out_sr_r[15];
			out_sr_r <= {out_sr_r[14:0], 1'b0};
		end
	end

	// Serial strobe
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			serial_strobe_out_r <= 1'b1;
		else if (shutdown_select_pin_low_s)
			serial_strobe_out_r <= 1'b1;
		else if (byte_go)
			serial_strobe_out_r <= conv_ext;
		else if (conv_done && state_r == apc_pkg::DEV_INT_CONV)
			serial_strobe_out_r <= 1'b1;
		else if (state_r == apc_pkg::DEV_EXT_CONV && fall)
			serial_strobe_out_r <= 1'b0;
	end

	// Drivers and status; pin high returns to service after the sync
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dout_oe_n_r <= 1'b1;
			serial_strobe_out_oe_n_r <= 1'b0;
			comp_internal_r <= 1'b0;
			hw_down_r <= 1'b0;
			conv_busy_r <= 1'b0;
		end
		else
		begin
			dout_oe_n_r <= ~cs_low;
			serial_strobe_out_oe_n_r <= ext_mode_r & ~cs_low;
			comp_internal_r <= shutdown_select_pin_high_s;
			hw_down_r <= shutdown_select_pin_low_s;
			conv_busy_r <= ~shutdown_select_pin_low_s & (state_r != apc_pkg::DEV_IDLE);
		end
	end

	assign link.dout = dout_r;
	assign link.dout_oe_n = dout_oe_n_r;
	assign link.serial_strobe_out = serial_strobe_out_r;
	assign link.serial_strobe_out_oe_n = serial_strobe_out_oe_n_r;
	assign power_mode = pd_r;
	assign ext_clock_mode = ext_mode_r;
	assign comp_internal = comp_internal_r;
	assign conv_busy = conv_busy_r;
	assign asleep = asleep_r;
	assign hw_down = hw_down_r;
	assign result = result_r;
endmodule

// ---- apc_host.sv ----
`timescale 1ns/1ps
module apc_host #(
	parameter int FULL_UP_CYC = apc_pkg::FULL_UP_CYC,
	parameter int EXTC_UP_CYC = apc_pkg::EXTC_UP_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	apc_link_if.host link
);
	logic [1:0] sync1_r;
	logic [1:0] sync2_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [9:0] cmd_r;
	logic pending_r;
	logic [1:0] shutdown_select_pin_cfg_r;
	apc_pkg::apc_host_state_type state_r;
	logic [apc_pkg::DLY_W-1:0] cnt_r;
	logic [apc_pkg::DLY_W-1:0] dly_r;
	logic [4:0] half_r;
	logic [4:0] bit_r;
	logic [7:0] tx_sr_r;
	logic [15:0] rx_sr_r;
	logic seen_low_r;
	logic [1:0] last_pd_r;
	logic was_low_r;
	logic sclk_r;
	logic cs_n_r;
	logic din_r;
	logic [31:0] rd_mux;
	logic mapped;
	logic wr_go;
	logic busy;
	logic half_tick;
	logic cold;
	logic [apc_pkg::DLY_W-1:0] up_dly;
	logic [apc_pkg::DLY_W-1:0] gap_cyc;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end
		else
		begin
			sync1_r <= {link.dout_line, link.serial_strobe_out_line};
			sync2_r <= sync1_r;
		end
	end

	assign busy = pending_r | (state_r != apc_pkg::H_IDLE);
	assign mapped = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'h0)
		& (paddr[7:4] == 4'h0);
	assign wr_go = psel & penable & pready_r & pwrite;
	assign half_tick = (half_r == 5'(apc_pkg::SCLK_HALF - 1));
	assign cold = was_low_r | (last_pd_r == apc_pkg::PD_FULL);

	always_comb
	begin
		rd_mux = 32'h00000000;
		case (paddr[7:0])
			apc_pkg::CMD_OFS: rd_mux = {22'h000000, cmd_r};
			apc_pkg::SHUTDOWN_SELECT_PIN_OFS: rd_mux = {30'h00000000, shutdown_select_pin_cfg_r};
			apc_pkg::STATUS_OFS: rd_mux = {29'h00000000,
				state_r == apc_pkg::H_BOOT, sync2_r[0], busy};
			apc_pkg::RXDATA_OFS: rd_mux = {16'h0000, rx_sr_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Power-up wait chosen from compensation and last power mode
	always_comb
	begin
		up_dly = '0;
		if (shutdown_select_pin_cfg_r == apc_pkg::SHUTDOWN_SELECT_PIN_HIGH)
		begin
			if (cold)
				up_dly = apc_pkg::DLY_W'(FULL_UP_CYC);
			else if (last_pd_r == apc_pkg::PD_FAST)
				up_dly = apc_pkg::DLY_W'(apc_pkg::FAST_UP_CYC);
		end
		else if (shutdown_select_pin_cfg_r == apc_pkg::SHUTDOWN_SELECT_PIN_FLOAT)
		begin
			if (cold)
				up_dly = apc_pkg::DLY_W'(EXTC_UP_CYC);
			else if (last_pd_r == apc_pkg::PD_FAST)
				up_dly = apc_pkg::DLY_W'(apc_pkg::EXT_SETTLE_CYC);
		end
	end

	assign gap_cyc = (shutdown_select_pin_cfg_r == apc_pkg::SHUTDOWN_SELECT_PIN_HIGH)
		? apc_pkg::DLY_W'(apc_pkg::GAP_INT_CYC)
		: apc_pkg::DLY_W'(apc_pkg::GAP_EXT_CYC);

	// APB slave, no wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end
		else
		begin
			pready_r <= psel & ~penable;
			pslverr_r <= psel & ~penable & ~mapped;
			prdata_r <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_r <= apc_pkg::CMD_RESET;
			shutdown_select_pin_cfg_r <= apc_pkg::SHUTDOWN_SELECT_PIN_RESET;
		end
		else if (wr_go && mapped)
		begin
			if (paddr[7:0] == apc_pkg::CMD_OFS && !pending_r)
				cmd_r <= pwdata[9:0];
			if (paddr[7:0] == apc_pkg::SHUTDOWN_SELECT_PIN_OFS && pwdata[1:0] != 2'h3)
				shutdown_select_pin_cfg_r <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pending_r <= 1'b0;
		else if (wr_go && mapped && paddr[7:0] == apc_pkg::CMD_OFS)
			pending_r <= 1'b1;
		else if (state_r == apc_pkg::H_IDLE)
			pending_r <= 1'b0;
	end

	// Frame sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= apc_pkg::H_BOOT;
			cnt_r <= '0;
			dly_r <= '0;
			half_r <= 5'h00;
			bit_r <= 5'h00;
			tx_sr_r <= 8'h00;
			rx_sr_r <= 16'h0000;
			seen_low_r <= 1'b0;
			last_pd_r <= apc_pkg::PD_RESET;
			was_low_r <= 1'b0;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			din_r <= 1'b0;
		end
		else
		begin
			if (shutdown_select_pin_cfg_r == apc_pkg::SHUTDOWN_SELECT_PIN_LOW)
				was_low_r <= 1'b1;
			half_r <= half_tick ? 5'h00 : half_r + 5'h01;
			case (state_r)
				apc_pkg::H_BOOT:
				begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == apc_pkg::DLY_W'(apc_pkg::BOOT_CYC - 1))
						state_r <= apc_pkg::H_IDLE;
				end
				apc_pkg::H_IDLE:
				begin
					if (pending_r)
					begin
						dly_r <= up_dly;
						last_pd_r <= cmd_r[1:0];
						was_low_r <= 1'b0;
						cnt_r <= '0;
						state_r <= apc_pkg::H_PWRUP;
					end
				end
				apc_pkg::H_PWRUP:
				begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r >= dly_r)
					begin
						cs_n_r <= 1'b0;
						din_r <= cmd_r[7];
						tx_sr_r <= cmd_r[7:0];
						half_r <= 5'h00;
						bit_r <= 5'h00;
						state_r <= apc_pkg::H_SHIFT;
					end
				end
				apc_pkg::H_SHIFT, apc_pkg::H_READ:
				begin
					if (half_tick && !sclk_r)
					begin
						sclk_r <= 1'b1;
						bit_r <= bit_r + 5'h01;
						if (state_r == apc_pkg::H_READ)
							rx_sr_r <= {rx_sr_r[14:0], sync2_r[1]};
					end
					else if (half_tick)
					begin
						sclk_r <= 1'b0;
						din_r <= tx_sr_r[6];
						tx_sr_r <= {tx_sr_r[6:0], 1'b0};
						if (state_r == apc_pkg::H_SHIFT
							&& bit_r == apc_pkg::CTRL_BITS)
						begin
							bit_r <= 5'h00;
							seen_low_r <= 1'b0;
							if (cmd_r[apc_pkg::CMD_WAIT_BIT])
								state_r <= apc_pkg::H_WSTRB;
							else if (cmd_r[apc_pkg::CMD_READ_BIT])
								state_r <= apc_pkg::H_READ;
							else
								state_r <= apc_pkg::H_GAP;
						end
						else if (state_r == apc_pkg::H_READ
							&& bit_r == apc_pkg::READ_BITS)
							state_r <= apc_pkg::H_GAP;
						cnt_r <= '0;
					end
				end
				apc_pkg::H_WSTRB:
				begin
					half_r <= 5'h00;
					if (!sync2_r[0])
						seen_low_r <= 1'b1;
					if (seen_low_r && sync2_r[0])
						state_r <= cmd_r[apc_pkg::CMD_READ_BIT]
							? apc_pkg::H_READ : apc_pkg::H_GAP;
					cnt_r <= '0;
				end
				apc_pkg::H_GAP:
				begin
					cs_n_r <= 1'b1;
					din_r <= 1'b0;
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r >= gap_cyc)
						state_r <= apc_pkg::H_IDLE;
				end
				default:
					state_r <= apc_pkg::H_IDLE;
			endcase
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign link.sclk = sclk_r;
	assign link.cs_n = cs_n_r;
	assign link.din = din_r;
	assign link.shutdown_select_pin_o = shutdown_select_pin_cfg_r[1];
	assign link.shutdown_select_pin_oe_n = (shutdown_select_pin_cfg_r == apc_pkg::SHUTDOWN_SELECT_PIN_FLOAT);
endmodule

// ---- apc_chk.sv ----
`timescale 1ns/1ps
module apc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic dout,
	input wire logic dout_oe_n,
	input wire logic serial_strobe_out,
	input wire logic serial_strobe_out_oe_n,
	input wire logic shutdown_select_pin_high,
	input wire logic shutdown_select_pin_float,
	input wire logic shutdown_select_pin_low
);
	logic [10:0] low_r;
	logic conv_r;
	logic st_lo;
	logic st_hi;

	assign st_lo = ~serial_strobe_out_oe_n & ~serial_strobe_out;
	assign st_hi = ~serial_strobe_out_oe_n & serial_strobe_out;

	// Length of the current driven-low strobe run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_r <= 11'h000;
		else if (!st_lo)
			low_r <= 11'h000;
		else if (low_r != 11'h7FF)
			low_r <= low_r + 11'h001;
	end

	// Set once a conversion has been signalled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conv_r <= 1'h0;
		else if (st_lo)
			conv_r <= 1'h1;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_reset_strobe;
		$rose(presetn) && !shutdown_select_pin_low |-> st_hi;
	endproperty
	a_reset_strobe: assert property (p_reset_strobe)
		else $error("strobe not high after reset");

	property p_zero_out;
		!conv_r |-> !(dout && !dout_oe_n);
	endproperty
	a_zero_out: assert property (p_zero_out)
		else $error("data out not zero before first conversion");

	property p_down_strobe;
		shutdown_select_pin_low [*4] |-> st_hi;
	endproperty
	a_down_strobe: assert property (p_down_strobe)
		else $error("strobe not held high in shutdown");

	property p_abort;
		$rose(shutdown_select_pin_low) && st_lo |-> ##[1:6] st_hi;
	endproperty
	a_abort: assert property (p_abort)
		else $error("conversion not aborted by shutdown");

	// Twelve internal clock periods; select high long enough to undrive
	property p_fast_len;
		(shutdown_select_pin_float && cs_n) [*5] |-> low_r < 11'h08C;
	endproperty
	a_fast_len: assert property (p_fast_len)
		else $error("fast internal conversion too long");

	property p_slow_len;
		(shutdown_select_pin_high && cs_n) [*5] |-> low_r < 11'h439;
	endproperty
	a_slow_len: assert property (p_slow_len)
		else $error("slow internal conversion too long");

	property p_slow_min;
		$rose(st_hi) && cs_n && shutdown_select_pin_high |-> low_r > 11'h40F;
	endproperty
	a_slow_min: assert property (p_slow_min)
		else $error("slow internal conversion too short");

	property p_no_start;
		(cs_n && st_hi) [*8] |=> !st_lo;
	endproperty
	a_no_start: assert property (p_no_start)
		else $error("conversion started with select high");
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [11:0] sample_value;
	logic [1:0] power_mode;
	logic ext_clock_mode;
	logic comp_internal;
	logic conv_busy;
	logic asleep;
	logic hw_down;
	logic [11:0] result;
	logic [31:0] rd_q;
	logic rd_err;
	logic boot_cs = 1'h0;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;

	apc_link_if link();
	apc_device apc_device_inst (.pclk(pclk), .presetn(presetn),
		.link(link.dev), .sample_value(sample_value),
		.power_mode(power_mode), .ext_clock_mode(ext_clock_mode),
		.comp_internal(comp_internal), .conv_busy(conv_busy),
		.asleep(asleep), .hw_down(hw_down), .result(result));
	apc_host #(.FULL_UP_CYC(60), .EXTC_UP_CYC(400)) apc_host_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link.host));
	apc_chk apc_chk_inst (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
		.dout(link.dout), .dout_oe_n(link.dout_oe_n), .serial_strobe_out(link.serial_strobe_out),
		.serial_strobe_out_oe_n(link.serial_strobe_out_oe_n), .shutdown_select_pin_high(link.shutdown_select_pin_high),
		.shutdown_select_pin_float(link.shutdown_select_pin_float), .shutdown_select_pin_low(link.shutdown_select_pin_low));

	initial
	begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end

	task summarize();
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'h1)
		begin
			err_total++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= {24'h000000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rd_q = prdata;
		rd_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task wait_idle();
		for (int n = 0; n < 4000; n++)
		begin
			apb(1'h0, apc_pkg::STATUS_OFS, 32'h0);
			if (rd_q[0] === 1'h0 && rd_q[2] === 1'h0)
				break;
		end
	endtask

	task frame(input logic [1:0] pd, input logic [11:0] smp);
		logic [15:0] exp;
		logic [9:0] cmd;
		sample_value <= smp;
		cmd = {1'h1, pd != apc_pkg::PD_EXT, 6'h23, pd};
		exp = (pd == apc_pkg::PD_EXT) ? {2'h0, smp, 2'h0} : {1'h0, smp, 3'h0};
		apb(1'h1, apc_pkg::CMD_OFS, {22'h0, cmd});
		wait_idle();
		apb(1'h0, apc_pkg::RXDATA_OFS, 32'h0);
		chk(rd_q === {16'h0, exp}, "read data");
		chk(result === smp, "result");
	endtask

	task t_boot();
		apb(1'h0, apc_pkg::STATUS_OFS, 32'h0);
		chk(rd_q[2] === 1'h1, "boot flag");
		chk(link.serial_strobe_out_line === 1'h1, "strobe after reset");
		chk(power_mode === apc_pkg::PD_INT, "mode after reset");
		apb(1'h0, 8'h10, 32'h0);
		chk(rd_err === 1'h1 && rd_q === 32'h0, "unmapped access");
		frame(apc_pkg::PD_INT, 12'h3C5);
		chk(boot_cs === 1'h0, "frame during boot");
	endtask

	task t_modes();
		logic [1:0] seq [4];
		seq = '{apc_pkg::PD_FULL, apc_pkg::PD_FAST, apc_pkg::PD_EXT,
			apc_pkg::PD_INT};
		for (int i = 0; i < 4; i++)
		begin
			frame(seq[i], 12'hA53 + 12'(i) * 12'h111);
			chk(power_mode === seq[i], "power bits");
			chk(asleep === ~seq[i][1], "sleep state");
			chk(ext_clock_mode === (seq[i] == apc_pkg::PD_EXT), "clock");
		end
	endtask

	task t_shutdown_select_pin();
		apb(1'h1, apc_pkg::SHUTDOWN_SELECT_PIN_OFS, 32'h1);
		repeat (6) @(posedge pclk);
		chk(comp_internal === 1'h0 && hw_down === 1'h0, "floating");
		frame(apc_pkg::PD_INT, 12'hFFF);
		sample_value <= 12'h5A6;
		apb(1'h1, apc_pkg::CMD_OFS, {24'h0, 6'h23, apc_pkg::PD_INT});
		wait_idle();
		chk(conv_busy === 1'h0 && result === 12'h5A6, "fast conv");
		apb(1'h1, apc_pkg::SHUTDOWN_SELECT_PIN_OFS, 32'h3);
		apb(1'h0, apc_pkg::SHUTDOWN_SELECT_PIN_OFS, 32'h0);
		chk(rd_q === 32'h1, "pin value 3 ignored");
		apb(1'h1, apc_pkg::SHUTDOWN_SELECT_PIN_OFS, 32'h2);
		repeat (6) @(posedge pclk);
		chk(comp_internal === 1'h1, "driven high");
	endtask

	task t_hwdown();
		apb(1'h1, apc_pkg::CMD_OFS, {24'h0, 6'h23, apc_pkg::PD_INT});
		wait_idle();
		// Slow conversion outlasts the frame gap; start bit would be lost
		for (int n = 0; n < 2000 && conv_busy !== 1'h0; n++)
			@(posedge pclk);
		apb(1'h1, apc_pkg::CMD_OFS, {24'h0, 6'h23, apc_pkg::PD_INT});
		for (int n = 0; n < 2000 && conv_busy !== 1'h1; n++)
			@(posedge pclk);
		chk(conv_busy === 1'h1, "conversion started");
		apb(1'h1, apc_pkg::SHUTDOWN_SELECT_PIN_OFS, 32'h0);
		repeat (4) @(posedge pclk);
		chk(conv_busy === 1'h0 && hw_down === 1'h1, "abort");
		chk(link.serial_strobe_out_line === 1'h1, "strobe in shutdown");
		wait_idle();
		apb(1'h1, apc_pkg::CMD_OFS, {24'h0, 6'h23, apc_pkg::PD_EXT});
		wait_idle();
		chk(power_mode === apc_pkg::PD_INT, "bits overridden");
		chk(conv_busy === 1'h0, "no conversion when down");
		apb(1'h1, apc_pkg::SHUTDOWN_SELECT_PIN_OFS, 32'h2);
		repeat (40) @(posedge pclk);
		chk(hw_down === 1'h0, "wake from pin");
		frame(apc_pkg::PD_INT, 12'h2B7);
	endtask

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (presetn === 1'h1 && link.cs_n === 1'h0
			&& cyc < 8 + apc_pkg::BOOT_CYC)
			boot_cs <= 1'h1;
		if (cyc == 60000)
		begin
			err_total++;
			summarize();
		end
	end

	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		sample_value = 12'h000;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		t_boot();
		t_modes();
		t_shutdown_select_pin();
		t_hwdown();
		summarize();
	end
endmodule
